// *** ltc_fifo.sv ***
// small first-in first-out buffer with valid/ready on both sides
`default_nettype none
module ltc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // filling side
  input wire logic [WIDTH-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  // draining side
  output logic [WIDTH-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);

  // depth must be a power of two so pointers wrap naturally
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("ltc_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;
  wire full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  wire empty = (wr_ptr_r == rd_ptr_r);
  wire do_push = in_valid_in && !full;
  wire do_pop = out_valid_out && out_ready_in;

  // handshake outputs straight from the pointers
  assign in_ready_out = !full;
  assign out_valid_out = !empty;
  assign out_data_out = mem_r[rd_ptr_r[AW-1:0]];

  // storage write
  always_ff @(posedge clk_sys_in)
  begin
    if (do_push)
    begin
      mem_r[wr_ptr_r[AW-1:0]] <= in_data_in;
    end
  end

  // pointers
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end
    else
    begin
      wr_ptr_r <= wr_ptr_r + (AW+1)'(do_push);
      rd_ptr_r <= rd_ptr_r + (AW+1)'(do_pop);
    end
  end
endmodule : ltc_fifo
`default_nettype wire

// *** ltc_mem_model.sv ***
// display memory model answering the controller's address bus
`default_nettype none
module ltc_mem_model (
  // address side
  input wire logic [15:0] ma_in,
  input wire logic cursor_timing_in,
  // attribute bits placed on the upper data lines
  input wire logic [4:0] attr_in,
  // data toward the controller
  output logic [15:0] md_out
);
  timeunit 1ns;
  timeprecision 100ps;
  ////////////////////////////////////////////////////////////////////////////
  // data follows the address at once; lines 8-10 carry address noise on purpose
  assign md_out = {attr_in[4:2], cursor_timing_in, attr_in[0], ma_in[10:8],
                   ma_in[7:0] ^ 8'h5a};
endmodule : ltc_mem_model
`default_nettype wire

// *** ltc_pkg.sv ***
// shared constants of the lcd timing controller: register map, fields, timing
`default_nettype none
package ltc_pkg;
  // register indices as seen through the index register
  localparam logic [4:0] IDX_HTOTAL = 5'h00;
  localparam logic [4:0] IDX_HDISP = 5'h01;
  localparam logic [4:0] IDX_ROW_RASTERS = 5'h09;
  localparam logic [4:0] IDX_CUR_FIRST = 5'h0a;
  localparam logic [4:0] IDX_CUR_LAST = 5'h0b;
  localparam logic [4:0] IDX_ORIGIN_HI = 5'h0c;
  localparam logic [4:0] IDX_ORIGIN_LO = 5'h0d;
  localparam logic [4:0] IDX_CURPOS_HI = 5'h0e;
  localparam logic [4:0] IDX_CURPOS_LO = 5'h0f;
  localparam logic [4:0] IDX_VIRT_WIDTH = 5'h12;
  localparam logic [4:0] IDX_FRAME_HI = 5'h13;
  localparam logic [4:0] IDX_FRAME_LO = 5'h14;
  localparam logic [4:0] IDX_FIRST_RASTER = 5'h15;
  localparam logic [4:0] IDX_MODE = 5'h16;
  // reset values of the register file
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [4:0] RST_FIVE = 5'h00;
  // mode register bit positions
  localparam int MODE_ON = 4;
  localparam int MODE_GFX = 3;
  localparam int MODE_WIDE = 2;
  localparam int MODE_BLINK = 1;
  localparam int MODE_ATTR = 0;
  // cursor first raster register fields
  localparam int CUR_MODE_HI = 6;
  localparam int CUR_MODE_LO = 5;
  localparam logic [1:0] CUR_STEADY = 2'h0;
  localparam logic [1:0] CUR_OFF = 2'h1;
  localparam logic [1:0] CUR_BLINK32 = 2'h2;
  localparam logic [1:0] CUR_BLINK64 = 2'h3;
  // frame counter bits giving 32 and 64 frame blink periods
  localparam int BLINK32_BIT = 4;
  localparam int BLINK64_BIT = 5;
  // memory data attribute bit positions
  localparam int MD_REVERSE = 11;
  localparam int MD_CURSOR = 12;
  localparam int MD_BLINK = 13;
  localparam int MD_BLANK_WHITE = 14;
  localparam int MD_BLANK_BLACK = 15;
  // dot clocks per memory cycle
  localparam int MCLK_DIV = 4;
  localparam logic [1:0] SLOT_LAST = 2'(MCLK_DIV - 1);
endpackage : ltc_pkg
`default_nettype wire

// *** ltc_timing.sv ***
// lcd timing controller: host register file, display counters, fetch and attributes
`default_nettype none
module ltc_timing #(
  parameter int FIFO_DEPTH = 4
) (
  // clock and resets
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic reset_n_in,
  // host bus
  input wire logic cs_n_in,
  input wire logic index_or_data_select_in,
  input wire logic wr_n_in,
  input wire logic rd_n_in,
  input wire logic [7:0] db_in,
  output logic [7:0] db_out,
  output logic db_oe_n_out,
  // mode select pins
  input wire logic on_pin_in,
  input wire logic graphic_pin_in,
  input wire logic wide_pin_in,
  input wire logic blink_enable_pin_in,
  input wire logic attribute_pin_in,
  // display memory
  input wire logic [15:0] memory_data_in,
  output logic [15:0] ma_out,
  output logic [4:0] ra_out,
  output logic mclk_out,
  output logic disp_tmg_out,
  output logic cursor_timing_out,
  // processed display words toward the panel shifter
  output logic [15:0] lcd_word_out,
  output logic lcd_valid_out,
  input wire logic lcd_ready_in
);
  if (FIFO_DEPTH != 4) begin : g_bad_depth
    $error("ltc_timing expects a display buffer of 4 words");
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: two flops before any logic
  localparam int SW = 8 + 4 + 5 + 16 + 1;
  logic [SW-1:0] sync1_r;
  logic [SW-1:0] sync2_r;
  logic wr_n_d_r;
  always_ff @(posedge clk_sys_in)
  begin
    sync1_r <= {db_in, cs_n_in, index_or_data_select_in, wr_n_in, rd_n_in,
                on_pin_in, graphic_pin_in, wide_pin_in, blink_enable_pin_in,
                attribute_pin_in, memory_data_in, reset_n_in};
    sync2_r <= sync1_r;
    wr_n_d_r <= sync2_r[23]; // previous synchronised write strobe
  end
  // bit order: data 33:26, select 25, index/data 24, write 23, read 22, pins 21:17
  wire [7:0] db_s = sync2_r[33:26];
  wire cs_n_s = sync2_r[25];
  wire rs_s = sync2_r[24];
  wire wr_n_s = sync2_r[23];
  wire rd_n_s = sync2_r[22];
  wire [4:0] pins_s = sync2_r[21:17];
  wire [15:0] md_s = sync2_r[16:1];
  wire reset_n_s = sync2_r[0];

  ////////////////////////////////////////////////////////////////////////////
  // register file
  logic [4:0] index_r;
  logic [7:0] htotal_r;
  logic [7:0] hdisp_r;
  logic [4:0] row_rasters_r;
  logic [6:0] cur_first_r;
  logic [4:0] cur_last_r;
  logic [15:0] origin_r;
  logic [15:0] curpos_r;
  logic [7:0] virt_width_r;
  logic [8:0] frame_rasters_r;
  logic [4:0] first_raster_r;
  logic [4:0] mode_reg_r;

  // write is taken at the rising edge of the write strobe while selected
  wire wr_take = wr_n_s && !wr_n_d_r && !cs_n_s;
  wire idx_write = wr_take && !rs_s;
  wire data_write = wr_take && rs_s;

  localparam logic [4:0] RST_FIVE_C = ltc_pkg::RST_FIVE;

  // index write and data write decode
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      index_r <= RST_FIVE_C;
      htotal_r <= ltc_pkg::RST_BYTE;
      hdisp_r <= ltc_pkg::RST_BYTE;
      row_rasters_r <= RST_FIVE_C;
      cur_first_r <= 7'h00;
      cur_last_r <= RST_FIVE_C;
      origin_r <= 16'h0000;
      curpos_r <= 16'h0000;
      virt_width_r <= ltc_pkg::RST_BYTE;
      frame_rasters_r <= 9'h000;
      first_raster_r <= RST_FIVE_C;
      mode_reg_r <= RST_FIVE_C;
    end
    else if (idx_write)
    begin
      index_r <= db_s[4:0];
    end
    else if (data_write)
    begin
      case (index_r)
        ltc_pkg::IDX_HTOTAL: htotal_r <= db_s;
        ltc_pkg::IDX_HDISP: hdisp_r <= db_s;
        ltc_pkg::IDX_ROW_RASTERS: row_rasters_r <= db_s[4:0];
        ltc_pkg::IDX_CUR_FIRST: cur_first_r <= db_s[6:0];
        ltc_pkg::IDX_CUR_LAST: cur_last_r <= db_s[4:0];
        ltc_pkg::IDX_ORIGIN_HI: origin_r[15:8] <= db_s;
        ltc_pkg::IDX_ORIGIN_LO: origin_r[7:0] <= db_s;
        ltc_pkg::IDX_CURPOS_HI: curpos_r[15:8] <= db_s;
        ltc_pkg::IDX_CURPOS_LO: curpos_r[7:0] <= db_s;
        ltc_pkg::IDX_VIRT_WIDTH: virt_width_r <= db_s;
        ltc_pkg::IDX_FRAME_HI: frame_rasters_r[8] <= db_s[0];
        ltc_pkg::IDX_FRAME_LO: frame_rasters_r[7:0] <= db_s;
        ltc_pkg::IDX_FIRST_RASTER: first_raster_r <= db_s[4:0];
        ltc_pkg::IDX_MODE: mode_reg_r <= db_s[4:0];
        default: ; // unassigned indices are swallowed
      endcase
    end
  end

  // read back: only the origin and cursor pairs answer
  wire readable = (index_r >= ltc_pkg::IDX_ORIGIN_HI) && (index_r <= ltc_pkg::IDX_CURPOS_LO);
  wire rd_active = !cs_n_s && !rd_n_s && rs_s && readable;
  wire [7:0] rd_mux = (index_r == ltc_pkg::IDX_ORIGIN_HI) ? origin_r[15:8] :
                      (index_r == ltc_pkg::IDX_ORIGIN_LO) ? origin_r[7:0] :
                      (index_r == ltc_pkg::IDX_CURPOS_HI) ? curpos_r[15:8] : curpos_r[7:0];
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      db_out <= 8'h00;
      db_oe_n_out <= 1'b1;
    end
    else
    begin
      db_out <= rd_active ? rd_mux : 8'h00;
      db_oe_n_out <= !rd_active;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // effective mode
  wire [4:0] mode_eff = pins_s | mode_reg_r;
  wire disp_on = mode_eff[ltc_pkg::MODE_ON];
  wire gfx = mode_eff[ltc_pkg::MODE_GFX];
  wire gfx1 = gfx && mode_eff[ltc_pkg::MODE_ATTR];
  wire gfx2 = gfx && !mode_eff[ltc_pkg::MODE_ATTR];
  wire wide = !gfx && mode_eff[ltc_pkg::MODE_WIDE];
  wire attr_on = !gfx && mode_eff[ltc_pkg::MODE_ATTR];
  wire blink_on = mode_eff[ltc_pkg::MODE_BLINK];

  ////////////////////////////////////////////////////////////////////////////
  // display counters
  logic [1:0] phase_r;
  logic [7:0] char_r;
  logic [4:0] ras_r;
  logic [8:0] line_r;
  logic [15:0] row_base_r;
  logic [5:0] frame_r;
  logic fifo_ready;

  wire cnt_clr = rst_in || !reset_n_s;
  wire slot_end = (phase_r == ltc_pkg::SLOT_LAST);
  wire in_disp = (char_r < hdisp_r) && disp_on;
  wire push = slot_end && in_disp;
  wire stall = push && !fifo_ready;
  wire line_end = (char_r == htotal_r);
  wire frame_end = (line_r == frame_rasters_r);
  wire row_end = gfx1 || (ras_r == row_rasters_r);
  wire [15:0] stride = (virt_width_r != 8'h00) ? {8'h00, virt_width_r} : {8'h00, hdisp_r};
  wire [7:0] char_addr = wide ? {1'b0, char_r[7:1]} : char_r;
  wire [4:0] ras_start = gfx ? 5'h00 : first_raster_r;
  // address of the next memory cycle; the cursor compare uses it too
  wire [15:0] ma_nxt = row_base_r + {8'h00, char_addr};

  // memory cycle phase, also the memory clock divider
  always_ff @(posedge clk_sys_in)
  begin
    if (cnt_clr)
      phase_r <= 2'h0;
    else if (!stall)
      phase_r <= phase_r + 2'h1;
  end

  // character, raster, line and frame counters
  always_ff @(posedge clk_sys_in)
  begin
    if (cnt_clr)
    begin
      char_r <= 8'h00;
      ras_r <= 5'h00;
      line_r <= 9'h000;
      row_base_r <= origin_r; // a fresh scan starts at the origin
      frame_r <= 6'h00;
    end
    else if (slot_end && !stall)
    begin
      char_r <= line_end ? 8'h00 : char_r + 8'h01;
      if (line_end && frame_end)
      begin
        line_r <= 9'h000;
        ras_r <= ras_start;
        row_base_r <= origin_r;
        frame_r <= frame_r + 6'h01;
      end
      else if (line_end)
      begin
        line_r <= line_r + 9'h001;
        ras_r <= row_end ? 5'h00 : ras_r + 5'h01;
        row_base_r <= row_end ? row_base_r + stride : row_base_r;
      end
    end
  end

  // memory address and raster address toward display memory
  always_ff @(posedge clk_sys_in)
  begin
    if (cnt_clr)
    begin
      ma_out <= 16'h0000;
      ra_out <= 5'h00;
      mclk_out <= 1'b0;
      disp_tmg_out <= 1'b0;
    end
    else
    begin
      ma_out <= ma_nxt;
      ra_out <= gfx1 ? 5'h00 : ras_r;
      mclk_out <= phase_r[1];
      disp_tmg_out <= in_disp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cursor timing
  wire [1:0] cur_mode = cur_first_r[ltc_pkg::CUR_MODE_HI:ltc_pkg::CUR_MODE_LO];
  wire cur_vis = (cur_mode == ltc_pkg::CUR_STEADY) ||
                 (cur_mode == ltc_pkg::CUR_BLINK32 && frame_r[ltc_pkg::BLINK32_BIT]) ||
                 (cur_mode == ltc_pkg::CUR_BLINK64 && frame_r[ltc_pkg::BLINK64_BIT]);
  // compared one cycle early so the registered flag lines up with ma_out
  // and reaches memory data bit 12 together with the fetched word
  wire cur_hit = (ma_nxt == curpos_r) && (ras_r >= cur_first_r[4:0]) &&
                 (ras_r <= cur_last_r);
  always_ff @(posedge clk_sys_in)
  begin
    if (cnt_clr)
      cursor_timing_out <= 1'b0;
    else
      cursor_timing_out <= cur_hit && cur_vis && !gfx && in_disp;
  end

  ////////////////////////////////////////////////////////////////////////////
  // attribute processing of the fetched word
  wire [7:0] code = md_s[7:0];
  wire blank_now = blink_on && md_s[ltc_pkg::MD_BLINK] && frame_r[ltc_pkg::BLINK64_BIT];
  wire [7:0] attr_dots = md_s[ltc_pkg::MD_BLANK_BLACK] ? 8'h00 :
                         md_s[ltc_pkg::MD_BLANK_WHITE] ? 8'hff :
                         blank_now ? 8'h00 :
                         (md_s[ltc_pkg::MD_REVERSE] ^ md_s[ltc_pkg::MD_CURSOR]) ? ~code : code;
  wire [7:0] char_dots = attr_on ? attr_dots : (md_s[ltc_pkg::MD_CURSOR] ? ~code : code);
  wire [15:0] word = gfx ? md_s : {8'h00, char_dots};

  // display buffer; a full buffer stalls the fetch counters
  ltc_fifo #(
    .WIDTH(16),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in(clk_sys_in),
    .rst_in(cnt_clr),
    .in_data_in(word),
    .in_valid_in(push),
    .in_ready_out(fifo_ready),
    .out_data_out(lcd_word_out),
    .out_valid_out(lcd_valid_out),
    .out_ready_in(lcd_ready_in)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  deselect_idle_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    cs_n_s |=> $stable(index_r) && $stable(origin_r))
    else $error("register changed while deselected");
  bus_undriven_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (!readable || !rs_s) |=> db_oe_n_out)
    else $error("bus driven for a write-only register");
  index_load_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    idx_write |=> index_r == $past(db_s[4:0]))
    else $error("index not loaded");
  mclk_div_a: assert property (@(posedge clk_sys_in) disable iff (cnt_clr)
    $rose(mclk_out) && !stall |-> ##4 $rose(mclk_out) || $past(stall, 1))
    else $error("memory clock not dot clock over four");
  cursor_gfx_a: assert property (@(posedge clk_sys_in) disable iff (cnt_clr)
    gfx ##1 gfx |-> !cursor_timing_out)
    else $error("cursor shown outside character mode");
  counter_clear_a: assert property (@(posedge clk_sys_in)
    !reset_n_s && !rst_in |=> char_r == 8'h00 && line_r == 9'h000 && $stable(mode_reg_r))
    else $error("reset pin did not clear only the counters");
  disp_off_a: assert property (@(posedge clk_sys_in) disable iff (cnt_clr)
    !disp_on |=> !disp_tmg_out)
    else $error("display timing while display off");
  frame_wrap_a: assert property (@(posedge clk_sys_in) disable iff (cnt_clr)
    line_r <= frame_rasters_r || $past(data_write))
    else $error("line counter beyond frame length");
  stall_hold_a: assert property (@(posedge clk_sys_in) disable iff (cnt_clr)
    stall |=> $stable(char_r) && $stable(phase_r))
    else $error("counters advanced while buffer full");
  origin_load_a: assert property (@(posedge clk_sys_in)
    cnt_clr |=> row_base_r == $past(origin_r))
    else $error("scan did not restart at the origin");
endmodule : ltc_timing
`default_nettype wire

// *** tb.sv ***
// self-checking bench of the lcd timing controller
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys_in;
  logic rst_in;
  logic reset_n_in;
  logic cs_n_in;
  logic index_or_data_select_in;
  logic wr_n_in;
  logic rd_n_in;
  logic [7:0] db_in;
  logic [7:0] db_out;
  logic db_oe_n_out;
  logic graphic_pin_in;
  logic wide_pin_in;
  logic attribute_pin_in;
  logic [15:0] memory_data_in;
  logic [15:0] ma_out;
  logic mclk_out;
  logic [4:0] attr;
  logic cursor_timing_out;
  logic [15:0] lcd_word_out;
  logic lcd_valid_out;
  logic lcd_ready_in;
  int bad_count;
  int checks;
  ////////////////////////////////////////////////////////////////////////////
  // design and memory model
  ltc_timing #(.FIFO_DEPTH(4)) dut_u (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .reset_n_in(reset_n_in),
    .cs_n_in(cs_n_in), .index_or_data_select_in(index_or_data_select_in),
    .wr_n_in(wr_n_in), .rd_n_in(rd_n_in), .db_in(db_in), .db_out(db_out),
    .db_oe_n_out(db_oe_n_out), .on_pin_in(1'b0), .graphic_pin_in(graphic_pin_in),
    .wide_pin_in(wide_pin_in), .blink_enable_pin_in(1'b0),
    .attribute_pin_in(attribute_pin_in), .memory_data_in(memory_data_in),
    .ma_out(ma_out), .ra_out(), .mclk_out(mclk_out), .disp_tmg_out(),
    .cursor_timing_out(cursor_timing_out), .lcd_word_out(lcd_word_out),
    .lcd_valid_out(lcd_valid_out), .lcd_ready_in(lcd_ready_in));
  ltc_mem_model mem_u (.ma_in(ma_out), .cursor_timing_in(cursor_timing_out),
    .attr_in(attr), .md_out(memory_data_in));
  // free-running dot clock
  always #5 clk_sys_in = ~clk_sys_in;
  ////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask : cyc
  // compare and count
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out
  // one write strobe, everything held three cycles around its rise
  task automatic bus_wr(input logic cs_n, input logic rs, input logic [7:0] d);
    cs_n_in = cs_n;
    index_or_data_select_in = rs;
    db_in = d;
    wr_n_in = 1'b0;
    cyc(3);
    wr_n_in = 1'b1;
    cyc(3);
    cs_n_in = 1'b1;
    db_in = ~d;
    cyc(3);
  endtask : bus_wr
  task automatic wr_reg(input logic [4:0] idx, input logic [7:0] d);
    bus_wr(1'b0, 1'b0, {3'h0, idx});
    bus_wr(1'b0, 1'b1, d);
  endtask : wr_reg
  // read through index, expecting the bus driven or left alone
  task automatic rd_reg(input logic [4:0] idx, input logic rs, input logic drv,
                        input logic [7:0] exp);
    int n;
    bus_wr(1'b0, 1'b0, {3'h0, idx});
    cs_n_in = 1'b0;
    index_or_data_select_in = rs;
    rd_n_in = 1'b0;
    n = 0;
    while (db_oe_n_out !== 1'b0 && n < 8)
    begin
      cyc(1);
      n++;
    end
    chk("bus drive", {15'h0, drv}, {15'h0, ~db_oe_n_out});
    if (drv)
      chk("read data", {8'h00, exp}, {8'h00, db_out});
    rd_n_in = 1'b1;
    cs_n_in = 1'b1;
    cyc(4);
    if (drv && n >= 8)
      close_out();
  endtask : rd_reg
  // take one word from the buffer once it shows valid
  task automatic pop(input logic [15:0] exp);
    int n;
    n = 0;
    while (lcd_valid_out !== 1'b1 && n < 300)
    begin
      cyc(1);
      n++;
    end
    if (n >= 300)
    begin
      chk("word wait", 16'h0001, 16'h0000);
      close_out();
    end
    chk("panel word", exp, lcd_word_out);
    lcd_ready_in = 1'b1;
    cyc(1);
    lcd_ready_in = 1'b0;
  endtask : pop
  // expected character-mode and graphic words for an address
  function automatic logic [15:0] cw(input logic [15:0] a, input logic inv);
    return {8'h00, (a[7:0] ^ 8'h5a) ^ {8{inv}}};
  endfunction : cw
  function automatic logic [15:0] gw(input logic [15:0] a);
    return {attr[4:2], 1'b0, attr[0], a[10:8], a[7:0] ^ 8'h5a};
  endfunction : gw
  // restart counters; buffer then fills and stalls the scan
  task automatic restart();
    lcd_ready_in = 1'b0;
    reset_n_in = 1'b0;
    cyc(4);
    reset_n_in = 1'b1;
    cyc(60);
  endtask : restart
  ////////////////////////////////////////////////////////////////////////////
  task automatic sc_regs();
    rd_reg(ltc_pkg::IDX_ORIGIN_HI, 1'b1, 1'b1, 8'h00);
    wr_reg(ltc_pkg::IDX_ORIGIN_HI, 8'h01);
    wr_reg(ltc_pkg::IDX_ORIGIN_LO, 8'h20);
    wr_reg(ltc_pkg::IDX_CURPOS_HI, 8'h0f);
    wr_reg(ltc_pkg::IDX_CURPOS_LO, 8'hf0);
    rd_reg(ltc_pkg::IDX_ORIGIN_HI, 1'b1, 1'b1, 8'h01);
    rd_reg(ltc_pkg::IDX_ORIGIN_LO, 1'b1, 1'b1, 8'h20);
    rd_reg(ltc_pkg::IDX_CURPOS_HI, 1'b1, 1'b1, 8'h0f);
    rd_reg(ltc_pkg::IDX_CURPOS_LO, 1'b1, 1'b1, 8'hf0);
    rd_reg(ltc_pkg::IDX_HTOTAL, 1'b1, 1'b0, 8'h00);
    rd_reg(ltc_pkg::IDX_ORIGIN_LO, 1'b0, 1'b0, 8'h00);
  endtask : sc_regs
  task automatic sc_ignore();
    wr_reg(5'h05, 8'hff);
    wr_reg(5'h10, 8'hff);
    bus_wr(1'b1, 1'b0, {3'h0, ltc_pkg::IDX_ORIGIN_LO});
    bus_wr(1'b1, 1'b1, 8'h77);
    rd_n_in = 1'b0;
    cyc(8);
    chk("deselected drive", 16'h0001, {15'h0, db_oe_n_out});
    rd_n_in = 1'b1;
    rd_reg(ltc_pkg::IDX_ORIGIN_LO, 1'b1, 1'b1, 8'h20);
  endtask : sc_ignore
  // 8 slots a line, 4 shown, one raster a row, 4 rasters a frame
  task automatic sc_char();
    logic [7:0] s;
    wr_reg(ltc_pkg::IDX_HTOTAL, 8'h07);
    wr_reg(ltc_pkg::IDX_HDISP, 8'h04);
    wr_reg(ltc_pkg::IDX_FRAME_LO, 8'h03);
    wr_reg(ltc_pkg::IDX_MODE, 8'h10);
    restart();
    rd_reg(ltc_pkg::IDX_ORIGIN_HI, 1'b1, 1'b1, 8'h01);
    for (int i = 0; i < 8; i++)
      pop(cw(16'h0120 + 16'(i), 1'b0));
    lcd_ready_in = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      cyc(1);
      s[i] = mclk_out;
    end
    chk("clock period", {12'h000, s[3:0]}, {12'h000, s[7:4]});
    chk("clock duty", 16'h000f, {12'h000, s[3:0] ^ {s[1:0], s[3:2]}});
    lcd_ready_in = 1'b0;
  endtask : sc_char
  task automatic sc_virt();
    wr_reg(ltc_pkg::IDX_VIRT_WIDTH, 8'h08);
    restart();
    for (int i = 0; i < 4; i++)
      pop(cw(16'h0120 + 16'(i), 1'b0));
    for (int i = 0; i < 4; i++)
      pop(cw(16'h0128 + 16'(i), 1'b0));
  endtask : sc_virt
  task automatic sc_modes();
    wide_pin_in = 1'b1;
    restart();
    for (int i = 0; i < 4; i++)
      pop(cw(16'h0120 + 16'(i / 2), 1'b0));
    wide_pin_in = 1'b0;
    attr = 5'h01;
    restart();
    pop(cw(16'h0120, 1'b0));
    attribute_pin_in = 1'b1;
    restart();
    pop(cw(16'h0120, 1'b1));
    pop(cw(16'h0121, 1'b1));
    graphic_pin_in = 1'b1;
    restart();
    pop(gw(16'h0120));
    pop(gw(16'h0121));
    attribute_pin_in = 1'b0;
    attr = 5'h00;
    wr_reg(ltc_pkg::IDX_ROW_RASTERS, 8'h01);
    restart();
    for (int i = 0; i < 8; i++)
      pop(gw(16'h0120 + 16'(i % 4)));
    graphic_pin_in = 1'b0;
    wr_reg(ltc_pkg::IDX_ROW_RASTERS, 8'h00);
  endtask : sc_modes
  // blank white, blank black, and blinking after 32 frames
  task automatic sc_attr();
    attribute_pin_in = 1'b1;
    attr = 5'h08;
    restart();
    pop(16'h00ff);
    attr = 5'h18;
    restart();
    pop(16'h0000);
    attr = 5'h04;
    wr_reg(ltc_pkg::IDX_MODE, 8'h12);
    restart();
    pop(cw(16'h0120, 1'b0));
    cyc(1);
    lcd_ready_in = 1'b1;
    cyc(4400);
    lcd_ready_in = 1'b0;
    pop(16'h0000);
    wr_reg(ltc_pkg::IDX_MODE, 8'h10);
    attribute_pin_in = 1'b0;
    attr = 5'h00;
  endtask : sc_attr
  task automatic sc_cursor();
    wr_reg(ltc_pkg::IDX_CURPOS_HI, 8'h01);
    wr_reg(ltc_pkg::IDX_CURPOS_LO, 8'h21);
    restart();
    pop(cw(16'h0120, 1'b0));
    pop(cw(16'h0121, 1'b1));
    pop(cw(16'h0122, 1'b0));
  endtask : sc_cursor
  ////////////////////////////////////////////////////////////////////////////
  // reset, scenarios, verdict
  initial
  begin
    clk_sys_in = 1'b0;
    rst_in = 1'b1;
    reset_n_in = 1'b1;
    cs_n_in = 1'b1;
    index_or_data_select_in = 1'b0;
    wr_n_in = 1'b1;
    rd_n_in = 1'b1;
    db_in = 8'h00;
    graphic_pin_in = 1'b0;
    wide_pin_in = 1'b0;
    attribute_pin_in = 1'b0;
    attr = 5'h00;
    lcd_ready_in = 1'b0;
    bad_count = 0;
    checks = 0;
    cyc(3);
    rst_in = 1'b0;
    cyc(3);
    sc_regs();
    sc_ignore();
    sc_char();
    sc_virt();
    sc_modes();
    sc_attr();
    sc_cursor();
    close_out();
  end
endmodule : tb
`default_nettype wire
